// file: include/tic_pkg.sv
// Constants, memory map, register map and states of the temperature indexed trim block
// Behaviour
// - In normal mode, every millisecond the offset trim DAC loads the offset table entry at the index.
// - Offset table holds 176 sixteen-bit entries addressed by temperature index.
// - Span trim DAC loads its code from a second 176-entry indexed table.
// - Temperatures below the lowest code select index zero.
// - Index saturates at AF hex and never wraps around.
// - One index step stands for roughly 1.5 degrees Celsius.
// - Write lock refuses changes to coefficients and the 52 user bytes.
// - High on the lock override input defeats the write lock.
// - One bidirectional serial pin, released whenever the output is sensed.
// - A 1 MHz clock output is gated by a configuration bit.
// - The amplifier coarse gain is a 4-bit setting, sixteen steps.
// - Nonvolatile memory is 768 by 8 holding words and 52 user bytes.
// - Four 16-bit DAC codes come from stored coefficients.
// - Temperature code is 8 bits spanning 00 to AF hex, used as index.
// - Locked refresh reloads config, both tempco words and both trim DACs.
// - Calibration mode unless lock byte is FF hex and override low.
package tic_pkg;
	localparam int NVM_DEPTH = 768;
	localparam int NVM_AW = 10;
	localparam int BYTE_W = 8;
	localparam int DAC_W = 16;
	localparam int IDX_W = 8;
	localparam int TEMP_RAW_W = 10;
	localparam int GAIN_W = 4;
	localparam logic [IDX_W-1:0] IDX_MIN = 8'h00;
	localparam logic [IDX_W-1:0] IDX_MAX = 8'haf;
	localparam logic [IDX_W-1:0] SPAN_SPLIT_IDX = 8'h80;
	localparam logic [NVM_AW-1:0] OFS_TBL_BASE = 10'h000;
	localparam logic [NVM_AW-1:0] SPAN_LO_BASE = 10'h200;
	localparam logic [NVM_AW-1:0] SPAN_HI_BASE = 10'h0a0;
	localparam logic [NVM_AW-1:0] CFG_ADDR = 10'h160;
	localparam logic [NVM_AW-1:0] OTC_ADDR = 10'h162;
	localparam logic [NVM_AW-1:0] STC_ADDR = 10'h164;
	localparam logic [NVM_AW-1:0] LOCK_ADDR = 10'h166;
	localparam logic [NVM_AW-1:0] USER_BASE = 10'h168;
	localparam int USER_BYTES = 52;
	localparam logic [BYTE_W-1:0] NVM_ERASED = 8'h00;
	localparam logic [BYTE_W-1:0] LOCK_SET = 8'hff;
	localparam logic [BYTE_W-1:0] LOCK_CLEAR = 8'h00;
	localparam logic [11:0] REG_NVM_ADDR = 12'h000;
	localparam logic [11:0] REG_NVM_DATA = 12'h004;
	localparam logic [11:0] REG_CONFIG = 12'h008;
	localparam logic [11:0] REG_OFS_TRIM = 12'h00c;
	localparam logic [11:0] REG_SPAN_TRIM = 12'h010;
	localparam logic [11:0] REG_OFS_TC = 12'h014;
	localparam logic [11:0] REG_SPAN_TC = 12'h018;
	localparam logic [11:0] REG_TEMP = 12'h01c;
	localparam logic [11:0] REG_STATUS = 12'h020;
	localparam logic [11:0] REG_SERIAL = 12'h024;
	localparam int CFG_CLK_EN_BIT = 0;
	localparam int CFG_GAIN_LSB = 2;
	localparam logic [DAC_W-1:0] CFG_RST = 16'h0000;
	localparam logic [DAC_W-1:0] DAC_RST = 16'h0000;
	localparam int ST_CAL_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_REFUSED_BIT = 2;
	localparam int ST_PIN_BIT = 3;
	localparam int ST_OVR_BIT = 4;
	localparam int SER_VAL_BIT = 0;
	localparam int SER_DRV_BIT = 1;
	localparam int CLK_PERIOD_NS = 10;
	localparam int REFRESH_PERIOD_NS = 1000000;
	localparam int REFRESH_CYCLES = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
	localparam int CLK_OUT_PERIOD_NS = 1000;
	localparam int CLK_OUT_HALF = CLK_OUT_PERIOD_NS / (2 * CLK_PERIOD_NS);
	localparam logic [3:0] FETCH_LAST = 4'h9;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_FETCH = 2'b10
	} tic_state_t;
endpackage

// file: rtl/tic_nvm.sv
// Byte-wide nonvolatile store modelled in flip-flops, two read ports
`timescale 1ns/100ps
module tic_nvm
	import tic_pkg::*;
#(
	parameter int DEPTH = NVM_DEPTH,
	parameter int AW = NVM_AW
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_wr_en,
	input wire logic [AW-1:0] i_wr_addr,
	input wire logic [BYTE_W-1:0] i_wr_data,
	input wire logic [AW-1:0] i_rd_a_addr,
	output logic [BYTE_W-1:0] o_rd_a_data,
	input wire logic [AW-1:0] i_rd_b_addr,
	output logic [BYTE_W-1:0] o_rd_b_data,
	output logic [BYTE_W-1:0] o_lock_byte
);
	logic [BYTE_W-1:0] mem_q [DEPTH];

	for (genvar g = 0; g < DEPTH; g++) begin : g_cell
		always_ff @(posedge i_sys_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				mem_q[g] <= NVM_ERASED;
			end else if (i_wr_en && (i_wr_addr == AW'(g))) begin
				mem_q[g] <= i_wr_data;
			end
		end
	end

	// Out-of-range addresses read as erased
	assign o_rd_a_data = (int'(i_rd_a_addr) < DEPTH) ? mem_q[i_rd_a_addr] : NVM_ERASED;
	assign o_rd_b_data = (int'(i_rd_b_addr) < DEPTH) ? mem_q[i_rd_b_addr] : NVM_ERASED;
	assign o_lock_byte = mem_q[LOCK_ADDR];
endmodule

// file: rtl/tic_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module tic_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_async,
	output logic o_level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic lvl_q;

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s1_q <= RST_VAL;
			s2_q <= RST_VAL;
			s3_q <= RST_VAL;
		end else begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// A change counts only once the second and third stage agree
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lvl_q <= RST_VAL;
		end else if (s2_q == s3_q) begin
			lvl_q <= s3_q;
		end
	end

	assign o_level = lvl_q;
endmodule

// file: rtl/tic_trim_ctrl.sv
// Temperature indexed trim controller: refresh engine, lock, APB registers, pins
`timescale 1ns/100ps
module tic_trim_ctrl
	import tic_pkg::*;
#(
	parameter int P_REFRESH_CYCLES = REFRESH_CYCLES,
	parameter int P_CLK_OUT_HALF = CLK_OUT_HALF
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	input wire logic signed [TEMP_RAW_W-1:0] i_temp_raw,
	input wire logic i_lock_override,
	input wire logic i_serial_io_pin_in,
	output logic o_serial_io_pin_out,
	output logic o_serial_io_pin_oe_n,
	output logic o_megahertz_clock_out,
	output logic [GAIN_W-1:0] o_pga_gain,
	output logic [DAC_W-1:0] o_offset_trim_dac,
	output logic [DAC_W-1:0] o_span_trim_dac,
	output logic [DAC_W-1:0] o_offset_tempco_dac,
	output logic [DAC_W-1:0] o_span_tempco_dac
);
	localparam int TMR_W = $clog2(P_REFRESH_CYCLES + 1);
	localparam int CDIV_W = $clog2(P_CLK_OUT_HALF + 1);

	tic_state_t state_q;
	logic [3:0] step_q;
	logic [IDX_W-1:0] idx_now;
	logic [IDX_W-1:0] idx_q;
	logic [BYTE_W-1:0] lo_q;
	logic [NVM_AW-1:0] fetch_addr;
	logic [BYTE_W-1:0] fetch_data;
	logic [TMR_W-1:0] tmr_q;
	logic tick;
	logic poweron_q;
	logic start;
	logic override_lvl;
	logic pin_lvl;
	logic [BYTE_W-1:0] lock_byte;
	logic normal_mode;
	logic [DAC_W-1:0] config_q;
	logic [DAC_W-1:0] ofs_trim_q;
	logic [DAC_W-1:0] span_trim_q;
	logic [DAC_W-1:0] ofs_tc_q;
	logic [DAC_W-1:0] span_tc_q;
	logic [NVM_AW-1:0] nvm_addr_q;
	logic [BYTE_W-1:0] nvm_rd_data;
	logic refused_q;
	logic [1:0] serial_q;
	logic pin_out_q;
	logic pin_oe_n_q;
	logic [CDIV_W-1:0] cdiv_q;
	logic clk_out_q;
	logic apb_wr;
	logic apb_rd;
	logic addr_hit;
	logic protected_reg;
	logic wr_refused;
	logic wr_ok;
	logic commit;

	// Override pin and serial pin arrive from outside the clock domain
	tic_sync #(.RST_VAL(1'b0)) u_sync_override (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_async(i_lock_override),
		.o_level(override_lvl)
	);

	tic_sync #(.RST_VAL(1'b1)) u_sync_pin (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_async(i_serial_io_pin_in),
		.o_level(pin_lvl)
	);

	tic_nvm u_nvm (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_wr_en(wr_ok && (i_paddr == REG_NVM_DATA)),
		.i_wr_addr(nvm_addr_q),
		.i_wr_data(i_pwdata[BYTE_W-1:0]),
		.i_rd_a_addr(nvm_addr_q),
		.o_rd_a_data(nvm_rd_data),
		.i_rd_b_addr(fetch_addr),
		.o_rd_b_data(fetch_data),
		.o_lock_byte(lock_byte)
	);

	// Any lock byte other than the set value is treated as unlocked
	assign normal_mode = (lock_byte == LOCK_SET) && !override_lvl;

	// The converter code is clamped; each step is about 1.5 C of die temperature
	always_comb begin
		if (i_temp_raw < 0) begin
			idx_now = IDX_MIN;
		end else if (i_temp_raw > $signed({2'b00, IDX_MAX})) begin
			idx_now = IDX_MAX;
		end else begin
			idx_now = i_temp_raw[IDX_W-1:0];
		end
	end

	// Millisecond timer runs freely so the refresh rate does not drift with mode changes
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tmr_q <= '0;
		end else if (tmr_q == TMR_W'(P_REFRESH_CYCLES - 1)) begin
			tmr_q <= '0;
		end else begin
			tmr_q <= tmr_q + TMR_W'(1);
		end
	end

	assign tick = (tmr_q == TMR_W'(P_REFRESH_CYCLES - 1));
	assign start = (state_q == ST_IDLE) && normal_mode && (tick || poweron_q);

	// Power-on refresh stays pending until the device is first found locked
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			poweron_q <= 1'b1;
		end else if (start) begin
			poweron_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_q <= ST_IDLE;
			step_q <= '0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (start) begin
						state_q <= ST_FETCH;
						step_q <= '0;
					end
				end
				ST_FETCH: begin
					// Unlocking mid-fetch aborts so software writes never race the engine
					if (!normal_mode || (step_q == FETCH_LAST)) begin
						state_q <= ST_IDLE;
					end
					step_q <= step_q + 4'h1;
				end
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			idx_q <= IDX_MIN;
		end else if (start) begin
			idx_q <= idx_now;
		end
	end

	// Byte address walk: config, two tempco words, offset entry, span entry
	always_comb begin
		fetch_addr = CFG_ADDR;
		unique case (step_q[3:1])
			3'd0: fetch_addr = CFG_ADDR;
			3'd1: fetch_addr = OTC_ADDR;
			3'd2: fetch_addr = STC_ADDR;
			3'd3: fetch_addr = OFS_TBL_BASE + {1'b0, idx_q, 1'b0};
			3'd4: begin
				// Span table is split across two regions of the store
				if (idx_q < SPAN_SPLIT_IDX) begin
					fetch_addr = SPAN_LO_BASE + {2'b00, idx_q[6:0], 1'b0};
				end else begin
					fetch_addr = SPAN_HI_BASE + {1'b0, idx_q, 1'b0};
				end
			end
			default: fetch_addr = CFG_ADDR;
		endcase
		fetch_addr = fetch_addr | {{(NVM_AW-1){1'b0}}, step_q[0]};
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			lo_q <= '0;
		end else if ((state_q == ST_FETCH) && !step_q[0]) begin
			lo_q <= fetch_data;
		end
	end

	// Odd steps commit a full word: high byte now, low byte from the step before
	assign commit = (state_q == ST_FETCH) && step_q[0] && normal_mode;

	// APB: zero wait state, every access completes in its first access cycle
	assign apb_wr = i_psel && i_penable && i_pwrite;
	assign apb_rd = i_psel && i_penable && !i_pwrite;
	assign o_pready = 1'b1;

	always_comb begin
		unique case (i_paddr)
			REG_NVM_ADDR, REG_NVM_DATA, REG_CONFIG, REG_OFS_TRIM, REG_SPAN_TRIM,
			REG_OFS_TC, REG_SPAN_TC, REG_TEMP, REG_STATUS, REG_SERIAL: addr_hit = 1'b1;
			default: addr_hit = 1'b0;
		endcase
	end

	assign protected_reg = (i_paddr == REG_NVM_DATA) || (i_paddr == REG_CONFIG) ||
		(i_paddr == REG_OFS_TRIM) || (i_paddr == REG_SPAN_TRIM) ||
		(i_paddr == REG_OFS_TC) || (i_paddr == REG_SPAN_TC);
	assign wr_refused = apb_wr && protected_reg && normal_mode;
	assign wr_ok = apb_wr && addr_hit && !wr_refused && (i_pstrb != 4'h0);
	assign o_pslverr = i_psel && i_penable && (!addr_hit || wr_refused);

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			nvm_addr_q <= '0;
		end else if (wr_ok && (i_paddr == REG_NVM_ADDR)) begin
			nvm_addr_q <= i_pwdata[NVM_AW-1:0];
		end
	end

	// Registers hold between refreshes; in calibration only software loads them
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			config_q <= CFG_RST;
		end else if (commit && (step_q[3:1] == 3'd0)) begin
			config_q <= {fetch_data, lo_q};
		end else if (wr_ok && (i_paddr == REG_CONFIG)) begin
			config_q <= i_pwdata[DAC_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ofs_tc_q <= DAC_RST;
		end else if (commit && (step_q[3:1] == 3'd1)) begin
			ofs_tc_q <= {fetch_data, lo_q};
		end else if (wr_ok && (i_paddr == REG_OFS_TC)) begin
			ofs_tc_q <= i_pwdata[DAC_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			span_tc_q <= DAC_RST;
		end else if (commit && (step_q[3:1] == 3'd2)) begin
			span_tc_q <= {fetch_data, lo_q};
		end else if (wr_ok && (i_paddr == REG_SPAN_TC)) begin
			span_tc_q <= i_pwdata[DAC_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			ofs_trim_q <= DAC_RST;
		end else if (commit && (step_q[3:1] == 3'd3)) begin
			ofs_trim_q <= {fetch_data, lo_q};
		end else if (wr_ok && (i_paddr == REG_OFS_TRIM)) begin
			ofs_trim_q <= i_pwdata[DAC_W-1:0];
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			span_trim_q <= DAC_RST;
		end else if (commit && (step_q[3:1] == 3'd4)) begin
			span_trim_q <= {fetch_data, lo_q};
		end else if (wr_ok && (i_paddr == REG_SPAN_TRIM)) begin
			span_trim_q <= i_pwdata[DAC_W-1:0];
		end
	end

	// Sticky refusal flag; a new refusal beats a write-one clear in the same cycle
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			refused_q <= 1'b0;
		end else if (wr_refused) begin
			refused_q <= 1'b1;
		end else if (wr_ok && (i_paddr == REG_STATUS) && i_pwdata[ST_REFUSED_BIT]) begin
			refused_q <= 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			serial_q <= 2'b00;
		end else if (wr_ok && (i_paddr == REG_SERIAL)) begin
			serial_q <= i_pwdata[1:0];
		end
	end

	// Pin is released in normal mode, leaving the shared line to the analog output
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_out_q <= 1'b1;
			pin_oe_n_q <= 1'b1;
		end else begin
			pin_out_q <= serial_q[SER_VAL_BIT];
			pin_oe_n_q <= !(serial_q[SER_DRV_BIT] && !normal_mode);
		end
	end

	// Clock output divider; gating holds the pin low and restarts the count
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cdiv_q <= '0;
			clk_out_q <= 1'b0;
		end else if (!config_q[CFG_CLK_EN_BIT]) begin
			cdiv_q <= '0;
			clk_out_q <= 1'b0;
		end else if (cdiv_q == CDIV_W'(P_CLK_OUT_HALF - 1)) begin
			cdiv_q <= '0;
			clk_out_q <= !clk_out_q;
		end else begin
			cdiv_q <= cdiv_q + CDIV_W'(1);
		end
	end

	always_comb begin
		o_prdata = 32'h0000_0000;
		if (apb_rd) begin
			unique case (i_paddr)
				REG_NVM_ADDR: o_prdata = {22'h000000, nvm_addr_q};
				REG_NVM_DATA: o_prdata = {24'h000000, nvm_rd_data};
				REG_CONFIG: o_prdata = {16'h0000, config_q};
				REG_OFS_TRIM: o_prdata = {16'h0000, ofs_trim_q};
				REG_SPAN_TRIM: o_prdata = {16'h0000, span_trim_q};
				REG_OFS_TC: o_prdata = {16'h0000, ofs_tc_q};
				REG_SPAN_TC: o_prdata = {16'h0000, span_tc_q};
				REG_TEMP: o_prdata = {16'h0000, idx_now, idx_q};
				REG_STATUS: o_prdata = {27'h0000000, override_lvl, pin_lvl, refused_q,
					(state_q == ST_FETCH), !normal_mode};
				REG_SERIAL: o_prdata = {30'h00000000, serial_q};
				default: o_prdata = 32'h0000_0000;
			endcase
		end
	end

	assign o_serial_io_pin_out = pin_out_q;
	assign o_serial_io_pin_oe_n = pin_oe_n_q;
	assign o_megahertz_clock_out = clk_out_q;
	assign o_pga_gain = config_q[CFG_GAIN_LSB +: GAIN_W];
	assign o_offset_trim_dac = ofs_trim_q;
	assign o_span_trim_dac = span_trim_q;
	assign o_offset_tempco_dac = ofs_tc_q;
	assign o_span_tempco_dac = span_tc_q;
endmodule

// file: sim/tic_host_model.sv
// Calibration host on the shared single-pin serial line
`timescale 1ns/100ps
module tic_host_model (
	input wire logic i_dev_out,
	input wire logic i_dev_oe_n,
	input wire logic i_host_en,
	input wire logic i_host_val,
	output wire logic o_line
);
	// Host backs off while the device drives, so the line never sees a contention
	wire logic host_drv = i_host_en && i_dev_oe_n;
	// Released line floats to the pull-up level
	assign o_line = !i_dev_oe_n ? i_dev_out : (host_drv ? i_host_val : 1'b1);
endmodule

// file: sim/tic_trim_ctrl_tb_top.sv
// Self-checking bench for the temperature indexed trim controller
`timescale 1ns/100ps
module tic_trim_ctrl_tb_top
	import tic_pkg::*;
;
	// Short refresh and clock-out periods keep the run small
	localparam int RC = 50;
	localparam int HALF = 5;
	typedef struct packed {logic [11:0] a; logic [31:0] w; logic [31:0] r; logic e;} tic_reg_row_t;
	typedef struct packed {logic [9:0] raw; logic [7:0] idx;} tic_temp_row_t;
	logic clk, rstn, psel, pen, pwr, ovr, host_en, pready, pslverr, err, pin_out, oe_n, mhz;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] gain;
	logic [15:0] ofs, span, otc, stc;
	logic signed [9:0] temp;
	wire logic pin_in;
	int num_errors, num_checks;
	tic_reg_row_t regs [7];
	tic_temp_row_t temps [7];
	logic [4:0] ser_rows [4];
	tic_trim_ctrl #(.P_REFRESH_CYCLES(RC), .P_CLK_OUT_HALF(HALF)) tic_trim_ctrl_i (
		.i_sys_clk(clk), .i_resetn(rstn), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hf), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_temp_raw(temp), .i_lock_override(ovr),
		.i_serial_io_pin_in(pin_in), .o_serial_io_pin_out(pin_out),
		.o_serial_io_pin_oe_n(oe_n), .o_megahertz_clock_out(mhz), .o_pga_gain(gain),
		.o_offset_trim_dac(ofs), .o_span_trim_dac(span), .o_offset_tempco_dac(otc),
		.o_span_tempco_dac(stc));
	tic_host_model tic_host_model_i (.i_dev_out(pin_out), .i_dev_oe_n(oe_n),
		.i_host_en(host_en), .i_host_val(1'b0), .o_line(pin_in));
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1 && n < 16) begin
			@(posedge clk);
			n++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (pready !== 1'b1) begin
			num_errors++;
			finish_test();
		end
	endtask
	task automatic nvm_b(input logic [9:0] a, input logic [7:0] b);
		apb(1'b1, REG_NVM_ADDR, {22'h0, a});
		apb(1'b1, REG_NVM_DATA, {24'h0, b});
	endtask
	// Low byte sits at the even address
	task automatic nvm_w(input logic [9:0] a, input logic [15:0] w);
		nvm_b(a, w[7:0]);
		nvm_b(a + 10'h001, w[15:8]);
	endtask
	function automatic logic [15:0] ofs_val(input logic [7:0] i);
		return {i, 8'h5a};
	endfunction
	function automatic logic [15:0] span_val(input logic [7:0] i);
		return {8'ha5, i};
	endfunction
	// Span table is split: low indices high in memory, upper indices below them
	function automatic logic [9:0] span_adr(input logic [7:0] i);
		return (i < 8'h80) ? 10'h200 + {1'b0, i, 1'b0} : 10'h1a0 + {1'b0, i - 8'h80, 1'b0};
	endfunction
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		int n;
		{rstn, psel, pen, pwr, ovr, host_en} = 6'h00;
		paddr = 12'h000;
		pwdata = 32'h0;
		temp = 10'sd20;
		num_errors = 0;
		num_checks = 0;
		regs = '{'{REG_OFS_TRIM, 32'hffff1234, 32'h1234, 1'b0},
			'{REG_SPAN_TRIM, 32'hbeef, 32'hbeef, 1'b0}, '{REG_OFS_TC, 32'h5a5a, 32'h5a5a, 1'b0},
			'{REG_SPAN_TC, 32'ha5a5, 32'ha5a5, 1'b0}, '{REG_CONFIG, 32'h35, 32'h35, 1'b0},
			'{12'h028, 32'h1, 32'h0, 1'b1}, '{12'h002, 32'h1, 32'h0, 1'b1}};
		temps = '{'{10'h3fb, 8'h00}, '{10'h000, 8'h00}, '{10'h07f, 8'h7f}, '{10'h080, 8'h80},
			'{10'h0af, 8'haf}, '{10'h0b0, 8'haf}, '{10'h1ff, 8'haf}};
		ser_rows = '{5'b10000, 5'b11001, 5'b00011, 5'b00110};
		repeat (8) @(posedge clk);
		chk({ofs, span}, 32'h0);
		chk({otc, stc}, 32'h0);
		chk({24'h0, gain, mhz, oe_n, pin_out, pready}, 32'h7);
		rstn <= 1'b1;
		foreach (regs[k]) begin
			apb(1'b1, regs[k].a, regs[k].w);
			chk({31'h0, err}, {31'h0, regs[k].e});
			apb(1'b0, regs[k].a, 32'h0);
			chk(rd, regs[k].r);
		end
		chk({ofs, span}, 32'h1234beef);
		chk({otc, stc}, 32'h5a5aa5a5);
		n = 0;
		while (mhz !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		n = 0;
		while (mhz === 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk(n, HALF);
		for (int g = 0; g < 16; g++) begin
			apb(1'b1, REG_CONFIG, {26'h0, 4'(g), 2'b00});
			// Register outputs settle only after the access edge
			@(posedge clk);
			chk({28'h0, gain}, g);
		end
		n = 0;
		repeat (3 * HALF) begin
			@(posedge clk);
			n += int'(mhz);
		end
		chk(n, 0);
		foreach (temps[k]) begin
			nvm_w(10'({temps[k].idx, 1'b0}), ofs_val(temps[k].idx));
			nvm_w(span_adr(temps[k].idx), span_val(temps[k].idx));
		end
		nvm_w(CFG_ADDR, 16'h0000);
		nvm_w(OTC_ADDR, 16'h1357);
		nvm_w(STC_ADDR, 16'h2468);
		nvm_b(LOCK_ADDR, LOCK_SET);
		foreach (temps[k]) begin
			@(posedge clk);
			temp <= temps[k].raw;
			repeat (2 * RC + 12) @(posedge clk);
			chk({ofs, span}, {ofs_val(temps[k].idx), span_val(temps[k].idx)});
			chk({otc, stc}, 32'h13572468);
		end
		apb(1'b0, REG_TEMP, 32'h0);
		chk(rd, 32'hafaf);
		apb(1'b1, REG_OFS_TRIM, 32'h1111);
		chk({31'h0, err}, 32'h1);
		@(posedge clk);
		chk({16'h0, ofs}, {16'h0, ofs_val(8'haf)});
		apb(1'b1, REG_NVM_ADDR, {22'h0, USER_BASE});
		apb(1'b1, REG_NVM_DATA, 32'h77);
		chk({31'h0, err}, 32'h1);
		apb(1'b0, REG_NVM_DATA, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({29'h0, rd[2], 1'b0, rd[0]}, 32'h4);
		@(posedge clk);
		ovr <= 1'b1;
		repeat (8) @(posedge clk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk({30'h0, rd[4], rd[0]}, 32'h3);
		apb(1'b1, REG_OFS_TRIM, 32'h4321);
		@(posedge clk);
		chk({15'h0, err, ofs}, 32'h4321);
		foreach (ser_rows[k]) begin
			apb(1'b1, REG_SERIAL, {30'h0, ser_rows[k][4:3]});
			host_en <= ser_rows[k][2];
			repeat (8) @(posedge clk);
			chk({30'h0, oe_n, pin_in}, {30'h0, ser_rows[k][1:0]});
			apb(1'b0, REG_STATUS, 32'h0);
			chk({31'h0, rd[3]}, {31'h0, ser_rows[k][0]});
		end
		host_en <= 1'b0;
		ovr <= 1'b0;
		repeat (2 * RC + 20) @(posedge clk);
		chk({ofs, span}, {ofs_val(8'haf), span_val(8'haf)});
		finish_test();
	end
endmodule

// file: sim/tic_trim_props.sv
// Port level assertions for the trim controller
`timescale 1ns/100ps
module tic_trim_props
	import tic_pkg::*;
#(
	parameter int P_REFRESH_CYCLES = REFRESH_CYCLES,
	parameter int P_CLK_OUT_HALF = CLK_OUT_HALF
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	input wire logic [31:0] o_prdata,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_megahertz_clock_out,
	input wire logic [GAIN_W-1:0] o_pga_gain,
	input wire logic [DAC_W-1:0] o_offset_trim_dac,
	input wire logic [DAC_W-1:0] o_span_trim_dac,
	input wire logic [DAC_W-1:0] o_offset_tempco_dac,
	input wire logic [DAC_W-1:0] o_span_tempco_dac
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);
	wire logic acc = i_psel && i_penable;
	wire logic wr_ok = acc && i_pwrite && (i_pstrb != 4'h0) && !o_pslverr;
	logic [7:0] hi_cnt_q;
	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			hi_cnt_q <= 8'h00;
		end else if (o_megahertz_clock_out) begin
			hi_cnt_q <= hi_cnt_q + 8'h01;
		end else begin
			hi_cnt_q <= 8'h00;
		end
	end
	pready_const_a: assert property (o_pready)
		else $error("pready dropped");
	rdata_idle_a: assert property (!acc |-> o_prdata == 32'h0 && !o_pslverr)
		else $error("read data or error outside access phase");
	unmapped_err_a: assert property (acc && (i_paddr > REG_SERIAL || i_paddr[1:0] != 2'b00)
		|-> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
	ofs_trim_wr_a: assert property (wr_ok && i_paddr == REG_OFS_TRIM
		|=> o_offset_trim_dac == $past(i_pwdata[15:0])) else $error("offset trim write lost");
	span_trim_wr_a: assert property (wr_ok && i_paddr == REG_SPAN_TRIM
		|=> o_span_trim_dac == $past(i_pwdata[15:0])) else $error("span trim write lost");
	tc_wr_a: assert property (wr_ok && i_paddr == REG_OFS_TC
		|=> o_offset_tempco_dac == $past(i_pwdata[15:0])) else $error("offset tempco lost");
	span_tc_wr_a: assert property (wr_ok && i_paddr == REG_SPAN_TC
		|=> o_span_tempco_dac == $past(i_pwdata[15:0])) else $error("span tempco lost");
	gain_wr_a: assert property (wr_ok && i_paddr == REG_CONFIG
		|=> o_pga_gain == $past(i_pwdata[5:2])) else $error("gain not taken from config");
	clk_high_len_a: assert property (o_megahertz_clock_out |-> hi_cnt_q < P_CLK_OUT_HALF)
		else $error("clock output high too long");
endmodule

bind tic_trim_ctrl tic_trim_props #(.P_REFRESH_CYCLES(P_REFRESH_CYCLES),
	.P_CLK_OUT_HALF(P_CLK_OUT_HALF)) tic_trim_props_i (.i_sys_clk, .i_resetn, .i_psel,
	.i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr,
	.o_megahertz_clock_out, .o_pga_gain, .o_offset_trim_dac, .o_span_trim_dac,
	.o_offset_tempco_dac, .o_span_tempco_dac);
